// *** i2cm_map.svh ***
// Constants for the I2C master transfer engine
`ifndef I2CM_MAP_SVH
`define I2CM_MAP_SVH

// System clock and default bus rate
`define I2CM_CLK_PERIOD_NS 10
`define I2CM_CLK_HZ 100000000
`define I2CM_SCL_HZ_DEFAULT 100000
`define I2CM_PHASES_PER_BIT 4
// Quarter-bit divider reload, derived from the rates above
`define I2CM_QTR_CYC ((`I2CM_CLK_HZ / (`I2CM_PHASES_PER_BIT * `I2CM_SCL_HZ_DEFAULT)) - 1)
`define I2CM_DIV_W 16
`define I2CM_DIV_RESET 16'(`I2CM_QTR_CYC)
// Smallest divider, leaves room for the two-stage pin synchroniser
`define I2CM_DIV_MIN 16'h0003

// Transfer geometry
`define I2CM_BYTE_W 8
`define I2CM_LEN_W 5
`define I2CM_FIFO_DEPTH 8
`define I2CM_LAST_BIT 3'h7

// Fixed bus address of the on-board serial EEPROM (8-bit form)
`define I2CM_EEPROM_ADDR 8'hAE

`endif

// *** i2cm_pkg.sv ***
// Types for the I2C master transfer engine
`default_nettype none
package i2cm_pkg;

   typedef enum logic [2:0] {
      I2CM_STAT_NONE = 3'h0,
      I2CM_STAT_OK = 3'h1,
      I2CM_STAT_ADDR_NACK = 3'h2,
      I2CM_STAT_DATA_NACK = 3'h3,
      I2CM_STAT_READ_CORRUPT = 3'h4,
      I2CM_STAT_SDA_STUCK = 3'h5,
      I2CM_STAT_SCL_STUCK = 3'h6
   } i2cm_code_t;

   typedef enum logic [2:0] {
      I2CM_ST_IDLE = 3'h0,
      I2CM_ST_CHECK = 3'h1,
      I2CM_ST_START = 3'h2,
      I2CM_ST_LOAD = 3'h3,
      I2CM_ST_BIT = 3'h4,
      I2CM_ST_ACK = 3'h5,
      I2CM_ST_STOP = 3'h6,
      I2CM_ST_DONE = 3'h7
   } i2cm_state_t;

   typedef struct packed {
      logic [6:0] addr;
      logic rd;
      logic [4:0] len;
   } i2cm_cmd_t;

   typedef struct packed {
      logic done;
      i2cm_code_t code;
   } i2cm_status_t;

endpackage
`default_nettype wire

// *** i2cm_fifo.sv ***
// Write-data FIFO with registered read port
`default_nettype none
module i2cm_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_flush,
   input wire logic i_in_valid,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_in_ready,
   output logic o_out_valid,
   output logic [WIDTH-1:0] o_out_data,
   input wire logic i_out_ready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_ptr_q;
   logic [AW-1:0] rd_ptr_q;
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic ready_q;
   logic out_valid_q;
   logic [WIDTH-1:0] out_data_q;

   wire push = i_in_valid && ready_q;
   wire out_pop = out_valid_q && i_out_ready;
   wire load = (cnt_q != '0) && (!out_valid_q || out_pop);
   wire [AW-1:0] wr_nxt = (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
   wire [AW-1:0] rd_nxt = (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;

   always_comb begin
      cnt_d = cnt_q;
      if (push && !load) begin
         cnt_d = cnt_q + 1'b1;
      end else if (load && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_q[wr_ptr_q] <= i_in_data;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst || i_flush) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         cnt_q <= '0;
         ready_q <= 1'b1;
         out_valid_q <= 1'b0;
         out_data_q <= '0;
      end else begin
         cnt_q <= cnt_d;
         ready_q <= (cnt_d != CW'(DEPTH));
         if (push) begin
            wr_ptr_q <= wr_nxt;
         end
         if (load) begin
            rd_ptr_q <= rd_nxt;
            out_data_q <= mem_q[rd_ptr_q];
            out_valid_q <= 1'b1;
         end else if (out_pop) begin
            out_valid_q <= 1'b0;
         end
      end
   end

   assign o_in_ready = ready_q;
   assign o_out_valid = out_valid_q;
   assign o_out_data = out_data_q;
endmodule
`default_nettype wire

// *** i2cm_master.sv ***
// I2C single-master transfer engine with per-transfer status
// What this block does
// - Before a START it samples SDA with the bus released and reports SDA stuck if it is low.
// - Before a START it samples SCL with the bus released and reports SCL stuck if it is low while SDA is high.
// - An address byte without acknowledge ends in a STOP and an address-NACK status.
// - A written data byte without acknowledge ends in a STOP and a data-NACK status.
// - The last read byte gets a released SDA; SDA seen low then gives a corrupted-read status.
// - A transfer with every acknowledge and no fault reports success.
// - The SCL rate is set by a host-loaded divider that stays readable.
// - The indicator is on while powered and drops while SDA is low during a transfer.
// - Every address and data byte is eight bits, most significant bit first.
// - The receiver acknowledges on the ninth pulse while the transmitter releases SDA.
// - START and STOP move SDA while SCL is high; all other SDA changes happen while SCL is low.
`include "i2cm_map.svh"
`default_nettype none
module i2cm_master #(
   parameter int FIFO_DEPTH = `I2CM_FIFO_DEPTH
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_go,
   input wire i2cm_pkg::i2cm_cmd_t i_cmd,
   input wire logic i_div_load,
   input wire logic [`I2CM_DIV_W-1:0] i_div,
   output logic [`I2CM_DIV_W-1:0] o_clk_div,
   input wire logic i_wr_valid,
   input wire logic [`I2CM_BYTE_W-1:0] i_wr_data,
   output logic o_wr_ready,
   output logic o_rd_valid,
   output logic [`I2CM_BYTE_W-1:0] o_rd_data,
   output logic o_busy,
   output i2cm_pkg::i2cm_status_t o_status,
   input wire logic i_scl,
   output logic o_scl_o,
   output logic o_scl_oe,
   input wire logic i_sda,
   output logic o_sda_o,
   output logic o_sda_oe,
   output logic o_led
);
   import i2cm_pkg::*;

   logic [1:0] scl_sync_q;
   logic [1:0] sda_sync_q;
   logic [`I2CM_DIV_W-1:0] div_q;
   logic [`I2CM_DIV_W-1:0] cnt_q;
   i2cm_state_t state_q;
   logic [1:0] phase_q;
   logic [2:0] bit_q;
   logic [`I2CM_BYTE_W-1:0] shift_q;
   logic [`I2CM_BYTE_W-1:0] rx_q;
   logic [`I2CM_LEN_W-1:0] left_q;
   logic [6:0] addr_q;
   logic rd_q;
   logic is_addr_q;
   logic ack_q;
   i2cm_code_t pend_q;
   i2cm_status_t stat_q;
   logic busy_q;
   logic scl_oe_q;
   logic sda_oe_q;
   logic rd_valid_q;
   logic [`I2CM_BYTE_W-1:0] rd_data_q;
   logic led_q;
   logic flush_q;
   logic fifo_valid;
   logic [`I2CM_BYTE_W-1:0] fifo_data;
   logic fifo_ready;

   // Synchronised bus levels, second stage only
   wire scl_s = scl_sync_q[1];
   wire sda_s = sda_sync_q[1];

   // Quarter-bit timing
   wire [`I2CM_DIV_W-1:0] div_eff = (div_q < `I2CM_DIV_MIN) ? `I2CM_DIV_MIN : div_q;
   wire tick = (cnt_q == div_eff);
   wire ph0 = (phase_q == 2'h0);
   wire ph1 = (phase_q == 2'h1);
   wire ph2 = (phase_q == 2'h2);
   wire ph3 = (phase_q == 2'h3);
   wire in_clk_st = (state_q == I2CM_ST_BIT) || (state_q == I2CM_ST_ACK);
   wire stretch = in_clk_st && ph2 && !scl_s;
   wire adv = tick && !stretch;

   // Byte decode
   wire receiving = rd_q && !is_addr_q;
   wire last_byte = (left_q == `I2CM_LEN_W'(1));
   wire tx_low = !receiving && !shift_q[7];
   wire ack_low = receiving && !last_byte;
   wire pop = (state_q == I2CM_ST_LOAD) && !rd_q && fifo_valid;
   wire bit_last = (bit_q == `I2CM_LAST_BIT);

   i2cm_fifo #(
      .WIDTH(`I2CM_BYTE_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_flush(flush_q),
      .i_in_valid(i_wr_valid),
      .i_in_data(i_wr_data),
      .o_in_ready(fifo_ready),
      .o_out_valid(fifo_valid),
      .o_out_data(fifo_data),
      .i_out_ready(pop)
   );

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         scl_sync_q <= 2'h3;
         sda_sync_q <= 2'h3;
      end else begin
         scl_sync_q <= {scl_sync_q[0], i_scl};
         sda_sync_q <= {sda_sync_q[0], i_sda};
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         div_q <= `I2CM_DIV_RESET;
      end else if (i_div_load) begin
         div_q <= i_div;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst || !busy_q || tick) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         led_q <= 1'b1;
      end else begin
         led_q <= !(busy_q && !sda_s);
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         state_q <= I2CM_ST_IDLE;
         phase_q <= 2'h0;
         bit_q <= 3'h0;
         shift_q <= 8'h00;
         rx_q <= 8'h00;
         left_q <= '0;
         addr_q <= 7'h00;
         rd_q <= 1'b0;
         is_addr_q <= 1'b0;
         ack_q <= 1'b1;
         pend_q <= I2CM_STAT_NONE;
         stat_q <= '{done: 1'b0, code: I2CM_STAT_NONE};
         busy_q <= 1'b0;
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
         rd_valid_q <= 1'b0;
         rd_data_q <= 8'h00;
         flush_q <= 1'b0;
      end else begin
         rd_valid_q <= 1'b0;
         flush_q <= 1'b0;
         case (state_q)
            I2CM_ST_IDLE: begin
               if (i_go) begin
                  stat_q <= '{done: 1'b0, code: I2CM_STAT_NONE};
                  addr_q <= i_cmd.addr;
                  rd_q <= i_cmd.rd;
                  left_q <= i_cmd.len;
                  pend_q <= I2CM_STAT_NONE;
                  busy_q <= 1'b1;
                  phase_q <= 2'h0;
                  state_q <= I2CM_ST_CHECK;
               end
            end
            I2CM_ST_CHECK: begin
               if (tick) begin
                  if (!sda_s) begin
                     pend_q <= I2CM_STAT_SDA_STUCK;
                     state_q <= I2CM_ST_DONE;
                  end else if (!scl_s) begin
                     pend_q <= I2CM_STAT_SCL_STUCK;
                     state_q <= I2CM_ST_DONE;
                  end else begin
                     state_q <= I2CM_ST_START;
                  end
               end
            end
            I2CM_ST_START: begin
               if (adv) begin
                  phase_q <= phase_q + 2'h1;
                  if (ph1) begin
                     sda_oe_q <= 1'b1;
                  end
                  if (ph2) begin
                     scl_oe_q <= 1'b1;
                  end
                  if (ph3) begin
                     shift_q <= {addr_q, rd_q};
                     is_addr_q <= 1'b1;
                     bit_q <= 3'h0;
                     state_q <= I2CM_ST_BIT;
                  end
               end
            end
            I2CM_ST_LOAD: begin
               if (rd_q) begin
                  shift_q <= 8'hFF;
                  state_q <= I2CM_ST_BIT;
               end else if (fifo_valid) begin
                  shift_q <= fifo_data;
                  state_q <= I2CM_ST_BIT;
               end
            end
            I2CM_ST_BIT: begin
               if (adv) begin
                  phase_q <= phase_q + 2'h1;
                  if (ph0) begin
                     sda_oe_q <= tx_low;
                  end
                  if (ph1) begin
                     scl_oe_q <= 1'b0;
                  end
                  if (ph2) begin
                     rx_q <= {rx_q[6:0], sda_s};
                  end
                  if (ph3) begin
                     scl_oe_q <= 1'b1;
                     shift_q <= {shift_q[6:0], 1'b0};
                     bit_q <= bit_q + 3'h1;
                     if (bit_last) begin
                        state_q <= I2CM_ST_ACK;
                     end
                  end
               end
            end
            I2CM_ST_ACK: begin
               if (adv) begin
                  phase_q <= phase_q + 2'h1;
                  if (ph0) begin
                     sda_oe_q <= ack_low;
                  end
                  if (ph1) begin
                     scl_oe_q <= 1'b0;
                  end
                  if (ph2) begin
                     ack_q <= sda_s;
                  end
                  if (ph3) begin
                     scl_oe_q <= 1'b1;
                     if (is_addr_q) begin
                        if (ack_q) begin
                           pend_q <= I2CM_STAT_ADDR_NACK;
                           state_q <= I2CM_ST_STOP;
                        end else if (left_q == '0) begin
                           pend_q <= I2CM_STAT_OK;
                           state_q <= I2CM_ST_STOP;
                        end else begin
                           is_addr_q <= 1'b0;
                           state_q <= I2CM_ST_LOAD;
                        end
                     end else if (receiving) begin
                        rd_valid_q <= 1'b1;
                        rd_data_q <= rx_q;
                        left_q <= left_q - 1'b1;
                        if (last_byte) begin
                           pend_q <= ack_q ? I2CM_STAT_OK : I2CM_STAT_READ_CORRUPT;
                           state_q <= I2CM_ST_STOP;
                        end else begin
                           state_q <= I2CM_ST_LOAD;
                        end
                     end else if (ack_q) begin
                        pend_q <= I2CM_STAT_DATA_NACK;
                        state_q <= I2CM_ST_STOP;
                     end else begin
                        left_q <= left_q - 1'b1;
                        if (last_byte) begin
                           pend_q <= I2CM_STAT_OK;
                           state_q <= I2CM_ST_STOP;
                        end else begin
                           state_q <= I2CM_ST_LOAD;
                        end
                     end
                  end
               end
            end
            I2CM_ST_STOP: begin
               if (adv) begin
                  phase_q <= phase_q + 2'h1;
                  if (ph0) begin
                     sda_oe_q <= 1'b1;
                  end
                  if (ph1) begin
                     scl_oe_q <= 1'b0;
                  end
                  if (ph2) begin
                     sda_oe_q <= 1'b0;
                  end
                  if (ph3) begin
                     state_q <= I2CM_ST_DONE;
                  end
               end
            end
            I2CM_ST_DONE: begin
               stat_q <= '{done: 1'b1, code: pend_q};
               busy_q <= 1'b0;
               scl_oe_q <= 1'b0;
               sda_oe_q <= 1'b0;
               flush_q <= 1'b1;
               state_q <= I2CM_ST_IDLE;
            end
            default: begin
               state_q <= I2CM_ST_IDLE;
            end
         endcase
      end
   end

   // Open-drain drivers only ever pull low
   assign o_scl_o = 1'b0;
   assign o_sda_o = 1'b0;
   assign o_scl_oe = scl_oe_q;
   assign o_sda_oe = sda_oe_q;
   assign o_clk_div = div_q;
   assign o_wr_ready = fifo_ready;
   assign o_rd_valid = rd_valid_q;
   assign o_rd_data = rd_data_q;
   assign o_busy = busy_q;
   assign o_status = stat_q;
   assign o_led = led_q;
endmodule
`default_nettype wire

// *** i2cm_master_assertions.sv ***
// Port checker for the I2C master
`default_nettype none
module i2cm_chk (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_go,
   input wire logic i_div_load,
   input wire logic [15:0] i_div,
   input wire logic [15:0] o_clk_div,
   input wire logic o_busy,
   input wire i2cm_pkg::i2cm_status_t o_status,
   input wire logic i_scl,
   input wire logic o_scl_oe,
   input wire logic i_sda,
   input wire logic o_sda_oe,
   input wire logic o_led
);
   import i2cm_pkg::*;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   a_go_busy: assert property (i_go && !o_busy |=> o_busy && o_status == 4'h0)
      else $error("busy or cleared status missing after go");
   a_status_hold: assert property (o_status.done && !(i_go && !o_busy) |=> $stable(o_status))
      else $error("status changed without go");
   a_div_load: assert property (i_div_load && i_div >= 16'h0003 |=> o_clk_div == $past(i_div))
      else $error("divider not loaded");
   a_div_keep: assert property (!i_div_load |=> $stable(o_clk_div))
      else $error("divider changed without load");
   a_led_idle: assert property (!o_busy [*3] |-> o_led)
      else $error("indicator off while idle");
   a_led_sda: assert property ((o_busy && o_sda_oe) [*5] |-> !o_led)
      else $error("indicator on while data held low");
   a_start_shape: assert property ($rose(o_sda_oe) && !o_scl_oe
      |-> o_sda_oe throughout (##[1:300] o_scl_oe))
      else $error("data moved while clock high outside start");
   a_stop_done: assert property ($fell(o_sda_oe) && !o_scl_oe |-> ##[1:300] o_status.done)
      else $error("data rose with clock high but no completion");
   a_bus_free: assert property ($rose(o_status.done) |-> !o_scl_oe && !o_sda_oe)
      else $error("status posted with bus still driven");
   a_sda_stuck: assert property ($rose(o_busy) ##0 (!i_sda [*8]) |-> (!o_scl_oe && !o_sda_oe)
      throughout (##[0:300] o_status == {1'b1, I2CM_STAT_SDA_STUCK}))
      else $error("data stuck low not reported");
   a_scl_stuck: assert property ($rose(o_busy) ##0 ((i_sda && !i_scl) [*8])
      |-> (!o_scl_oe && !o_sda_oe)
      throughout (##[0:300] o_status == {1'b1, I2CM_STAT_SCL_STUCK}))
      else $error("clock stuck low not reported");
endmodule
`default_nettype wire

// *** i2cm_slave.sv ***
// Behavioural I2C slave model
`default_nettype none
module i2cm_slave #(
   parameter logic [6:0] ADDR = 7'h57
) (
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic i_nack_data,
   input wire logic i_corrupt,
   output logic o_sda_oe,
   output logic [7:0] o_last_wr
);
   timeunit 1ns;
   timeprecision 100ps;
   task automatic get(output logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         @(posedge i_scl);
         b[i] = i_sda;
      end
   endtask
   task automatic ack(input logic a);
      @(negedge i_scl);
      o_sda_oe = a;
      @(negedge i_scl);
      o_sda_oe = 1'b0;
   endtask
   task automatic put(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         o_sda_oe = !b[i];
         @(negedge i_scl);
      end
      o_sda_oe = i_corrupt;
      @(posedge i_scl);
   endtask
   task automatic run();
      logic [7:0] b;
      logic [7:0] n;
      logic nk;
      get(b);
      if (b[7:1] !== ADDR) return;
      ack(1'b1);
      n = 8'hC3;
      forever begin
         if (b[0]) begin
            put(n);
            n = n - 8'h01;
            nk = i_sda | i_corrupt;
            @(negedge i_scl);
            o_sda_oe = 1'b0;
            if (nk) return;
         end else begin
            get(o_last_wr);
            ack(!i_nack_data);
            if (i_nack_data) return;
         end
      end
   endtask
   initial begin
      o_sda_oe = 1'b0;
      o_last_wr = 8'h00;
      forever begin
         @(negedge i_sda iff i_scl === 1'b1);
         fork : frame
            run();
            @(posedge i_sda iff i_scl === 1'b1);
         join_any
         disable fork;
         o_sda_oe = 1'b0;
      end
   end
endmodule
`default_nettype wire

// *** i2cm_master_tb.sv ***
// Self-checking bench for the I2C master
`default_nettype none
module i2cm_master_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import i2cm_pkg::*;
   logic i_clk, i_sys_rst, i_go, i_div_load, i_wr_valid;
   i2cm_cmd_t i_cmd;
   i2cm_status_t o_status;
   logic [15:0] i_div, o_clk_div;
   logic [7:0] i_wr_data, o_rd_data, last_wr;
   logic o_wr_ready, o_rd_valid, o_busy, scl_oe, sda_oe, sl_oe, led;
   logic nack_d, corrupt, hold_sda, hold_scl, scl_o, sda_o;
   logic [7:0] rq[$];
   int mismatches, comparisons, got;
   wire scl = !(scl_oe | hold_scl);
   wire sda = !(sda_oe | sl_oe | hold_sda);
   i2cm_master u_dut (.i_clk, .i_sys_rst, .i_go, .i_cmd, .i_div_load, .i_div, .o_clk_div,
      .i_wr_valid, .i_wr_data, .o_wr_ready, .o_rd_valid, .o_rd_data, .o_busy, .o_status,
      .i_scl(scl), .o_scl_o(scl_o), .o_scl_oe(scl_oe), .i_sda(sda), .o_sda_o(sda_o),
      .o_sda_oe(sda_oe), .o_led(led));
   i2cm_slave u_slave (.i_scl(scl), .i_sda(sda), .i_nack_data(nack_d), .i_corrupt(corrupt),
      .o_sda_oe(sl_oe), .o_last_wr(last_wr));
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = !i_clk;
   end
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic print_verdict();
      if (mismatches == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic fill(input int n);
      got = 0;
      while (o_wr_ready === 1'b1 && got < n) begin
         i_wr_valid = 1'b1;
         i_wr_data = 8'h10 + 8'(got);
         @(negedge i_clk);
         got++;
      end
      i_wr_valid = 1'b0;
   endtask
   task automatic xfer(input logic [6:0] a, input logic r, input logic [4:0] n);
      int t;
      rq.delete();
      i_cmd = {a, r, n};
      i_go = 1'b1;
      @(negedge i_clk);
      i_go = 1'b0;
      chk("busy", o_busy, 16'h0001);
      chk("status clear", 16'(o_status), 16'h0000);
      t = 0;
      while (o_busy === 1'b1 && t < 20000) begin
         @(negedge i_clk);
         if (o_rd_valid === 1'b1) rq.push_back(o_rd_data);
         t++;
      end
      chk("idle", o_busy, 16'h0000);
      repeat (3) @(negedge i_clk);
   endtask
   function automatic logic [15:0] st(input i2cm_code_t c);
      return {12'h000, 1'b1, c};
   endfunction
   task automatic s_reset();
      chk("div reset", o_clk_div, 16'h00F9);
      chk("led", led, 16'h0001);
      chk("pins low", 16'({scl_o, sda_o}), 16'h0000);
      chk("status reset", 16'(o_status), 16'h0000);
      i_div = 16'h0003;
      i_div_load = 1'b1;
      @(negedge i_clk);
      i_div_load = 1'b0;
      chk("div", o_clk_div, 16'h0003);
   endtask
   task automatic s_write();
      fill(2);
      xfer(7'h57, 1'b0, 5'h02);
      chk("wr status", 16'(o_status), st(I2CM_STAT_OK));
      chk("wr byte", last_wr, 16'h0011);
   endtask
   task automatic s_fifo();
      fill(20);
      chk("fifo", 16'(got), 16'h0009);
      fork
         begin
            repeat (200) @(negedge i_clk);
            @(negedge i_clk iff scl_oe === 1'b1);
            hold_scl = 1'b1;
            repeat (40) @(negedge i_clk);
            hold_scl = 1'b0;
         end
      join_none
      xfer(7'h57, 1'b0, 5'h09);
      chk("fifo status", 16'(o_status), st(I2CM_STAT_OK));
      chk("fifo last", last_wr, 16'h0018);
   endtask
   task automatic s_nacks();
      xfer(7'h22, 1'b0, 5'h00);
      chk("addr nack", 16'(o_status), st(I2CM_STAT_ADDR_NACK));
      xfer(7'h57, 1'b0, 5'h00);
      chk("probe", 16'(o_status), st(I2CM_STAT_OK));
      nack_d = 1'b1;
      fill(2);
      xfer(7'h57, 1'b0, 5'h02);
      nack_d = 1'b0;
      chk("data nack", 16'(o_status), st(I2CM_STAT_DATA_NACK));
      chk("nack byte", last_wr, 16'h0010);
   endtask
   task automatic s_read();
      xfer(7'h57, 1'b1, 5'h03);
      chk("rd status", 16'(o_status), st(I2CM_STAT_OK));
      chk("rd count", 16'(rq.size()), 16'h0003);
      for (int k = 0; k < 3 && k < rq.size(); k++) begin
         chk("rd byte", rq[k], 16'h00C3 - 16'(k));
      end
      corrupt = 1'b1;
      xfer(7'h57, 1'b1, 5'h01);
      corrupt = 1'b0;
      chk("corrupt", 16'(o_status), st(I2CM_STAT_READ_CORRUPT));
   endtask
   task automatic s_stuck();
      hold_sda = 1'b1;
      xfer(7'h57, 1'b0, 5'h00);
      hold_sda = 1'b0;
      chk("sda stuck", 16'(o_status), st(I2CM_STAT_SDA_STUCK));
      hold_scl = 1'b1;
      xfer(7'h57, 1'b0, 5'h00);
      hold_scl = 1'b0;
      chk("scl stuck", 16'(o_status), st(I2CM_STAT_SCL_STUCK));
   endtask
   initial begin
      {i_sys_rst, i_go, i_div_load, i_wr_valid} = 4'h8;
      {nack_d, corrupt, hold_sda, hold_scl} = 4'h0;
      i_cmd = '0;
      i_div = 16'h0000;
      i_wr_data = 8'h00;
      repeat (12) @(negedge i_clk);
      i_sys_rst = 1'b0;
      s_reset();
      s_write();
      s_fifo();
      s_nacks();
      s_read();
      s_stuck();
      print_verdict();
   end
   initial begin
      #300000;
      mismatches++;
      print_verdict();
   end
endmodule
bind i2cm_master i2cm_chk u_chk (.i_clk, .i_sys_rst, .i_go, .i_div_load, .i_div, .o_clk_div,
   .o_busy, .o_status, .i_scl, .o_scl_oe, .i_sda, .o_sda_oe, .o_led);
`default_nettype wire
